// *** cod_decoder.sv ***
// Opcode decoder, flag update and execution-state counter
// Function
// RULE_01 - Affected add, subtract and compare set half-carry on a carry or borrow out of bit 11, else clear it. Code: word size only, byte size keeps h.
// RULE_02 - Extended add and subtract with carry keep the old zero flag on a zero result and clear it otherwise.
// RULE_03 - Decimal adjust sets carry when the adjustment carries, else keeps the carry from before.
// RULE_04 - Block copy takes four states per byte plus nine, the byte count being the copy count low byte.
// RULE_05 - Unsigned divide sets negative when the divisor sign bit is one, else clears it.
// RULE_06 - Unsigned divide sets zero when the divisor is zero, else clears it.
// RULE_07 - The primary operation comes from bits 15 to 8 of the first word, high nibble row, low nibble column.
// RULE_08 - Shared first-byte cells are split by bit 7 of the first word.
// RULE_09 - High nibble 4 decodes as sixteen conditional branches in the listed condition order.
// RULE_10 - Push and pop are the indirect move through the stack pointer with no opcode of their own.
// RULE_11 - Execution length is the sum over six cycle types of count times that type's state length.
// RULE_12 - On-chip memory accesses take two states and internal cycles one state.
// RULE_13 - A byte access to a peripheral takes two or three states depending on the module.
// RULE_14 - Block copy repeats a byte move with pointer increments and count decrement until the count is zero.
// RULE_15 - High nibbles 8 to F decode as byte immediate add, addc, compare, subc, or, xor, and, move.
`default_nettype none
module cod_decoder
    import cod_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Instruction
    input wire logic issue,
    input wire logic [15:0] instr_word,
    // Operands
    input wire logic [15:0] operand_a,
    input wire logic [15:0] operand_b,
    input wire logic is_subtract,
    input wire logic word_size,
    input wire logic [7:0] adjust_value,
    input wire logic adjust_carry,
    input wire logic [15:0] divisor,
    input wire logic [3:0] stack_ptr_reg,
    // Cycle counts and access location
    input wire cod_cycles_type cycles,
    input wire logic data_in_periph,
    input wire logic periph_slow,
    // Block copy operands
    input wire logic [7:0] copy_count_reg,
    input wire logic [15:0] copy_source_ptr,
    input wire logic [15:0] copy_dest_ptr,
    // Memory port
    output logic mem_rd,
    output logic mem_wr,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Results
    output cod_decode_type decoded,
    output cod_flags_type condition_flags_reg,
    output logic [11:0] exec_states,
    output logic copy_busy,
    output logic copy_done,
    output logic [7:0] copy_count_out,
    output logic [15:0] copy_source_out,
    output logic [15:0] copy_dest_out
);
    typedef struct packed {
        cod_decode_type dec;
        cod_flags_type flags;
        logic [11:0] states;
    } cod_state_type;

    cod_state_type s_r, s_nxt;
    cod_decode_type dec_c;
    logic [7:0] first_byte;
    logic [3:0] row;
    logic [3:0] col;
    logic shared_sel;
    logic [12:0] low_sum;
    logic [16:0] full_sum;
    logic [15:0] result;
    logic [3:0] data_len;
    logic [11:0] cycle_states;
    logic copy_start;
    logic copy_done_w;
    logic [11:0] copy_states;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode decode
    assign first_byte = instr_word[15:8]; // RULE_07
    assign row = first_byte[7:4];
    assign col = first_byte[3:0];
    assign shared_sel = instr_word[SHARED_SEL_BIT]; // RULE_08

    always_comb begin
        dec_c.op = OP_OTHER;
        dec_c.cond = 4'h0;
        dec_c.imm_byte = 1'b0;
        if (row == BRANCH_ROW) begin
            dec_c.op = OP_BRANCH; // RULE_09
            dec_c.cond = col;
        end else if (row >= IMM_ROW_FIRST) begin
            dec_c.imm_byte = 1'b1; // RULE_15
            case (row)
                4'h8: dec_c.op = OP_ADD;
                4'h9: dec_c.op = OP_ADD_WITH_CARRY_INSTR;
                4'hA: dec_c.op = OP_CMP;
                4'hB: dec_c.op = OP_SUB_WITH_CARRY_INSTR;
                4'hC: dec_c.op = OP_OR;
                4'hD: dec_c.op = OP_XOR;
                4'hE: dec_c.op = OP_AND;
                default: dec_c.op = OP_MOV;
            endcase
        end else begin
            case (first_byte)
                COPY_OPCODE: dec_c.op = OP_COPY;
                DIVIDE_OPCODE: dec_c.op = OP_DIVIDE;
                DAA_OPCODE: dec_c.op = OP_DAA;
                DAS_OPCODE: dec_c.op = OP_DAS;
                ADD_WITH_CARRY_INSTR_OPCODE: dec_c.op = OP_ADD_WITH_CARRY_INSTR;
                SUB_WITH_CARRY_INSTR_OPCODE: dec_c.op = OP_SUB_WITH_CARRY_INSTR;
                8'h08, 8'h09: dec_c.op = OP_ADD;
                8'h18, 8'h19: dec_c.op = OP_SUB;
                8'h1C, 8'h1D: dec_c.op = OP_CMP;
                INDIRECT_MOVE_OPCODE: dec_c.op = (instr_word[6:4] == stack_ptr_reg[2:0]) ?
                    OP_PUSH_POP : OP_MOV; // RULE_10
                8'h11, 8'h17, 8'h67, 8'h74, 8'h75, 8'h76, 8'h77:
                    dec_c.op = shared_sel ? OP_SHARED_B : OP_SHARED_A; // RULE_08
                default: dec_c.op = OP_OTHER;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic for flags
    always_comb begin
        if (is_subtract) begin
            low_sum = {1'b0, operand_a[11:0]} - {1'b0, operand_b[11:0]};
            full_sum = {1'b0, operand_a} - {1'b0, operand_b};
        end else begin
            low_sum = {1'b0, operand_a[11:0]} + {1'b0, operand_b[11:0]};
            full_sum = {1'b0, operand_a} + {1'b0, operand_b};
        end
        result = word_size ? full_sum[15:0] : {8'h00, full_sum[7:0]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Execution-state sum
    always_comb begin
        if (data_in_periph) begin
            data_len = periph_slow ? PERIPH_SLOW_STATES : PERIPH_FAST_STATES; // RULE_13
        end else begin
            data_len = MEM_STATES; // RULE_12
        end
        // Widen before multiplying so that a product above 15 keeps its upper bits
        cycle_states = (12'(cycles.fetch) * 12'(MEM_STATES)) + (12'(cycles.branch_read) * 12'(MEM_STATES)) // RULE_11
            + (12'(cycles.stack) * 12'(MEM_STATES)) + (12'(cycles.byte_data) * 12'(data_len))
            + (12'(cycles.word_data) * 12'(MEM_STATES)) + (12'(cycles.internal) * 12'(INTERNAL_STATES));
    end

    ////////////////////////////////////////////////////////////////////////////
    // State update
    assign copy_start = issue && (dec_c.op == OP_COPY);

    always_comb begin
        s_nxt = s_r;
        if (issue) begin
            s_nxt.dec = dec_c;
            s_nxt.states = cycle_states;
            case (dec_c.op)
                OP_ADD, OP_SUB, OP_CMP: begin
                    if (word_size) begin
                        s_nxt.flags.h = low_sum[12]; // RULE_01
                    end
                    s_nxt.flags.z = (result == 16'h0000);
                    s_nxt.flags.c = word_size ? full_sum[16] : full_sum[8];
                end
                OP_ADD_WITH_CARRY_INSTR, OP_SUB_WITH_CARRY_INSTR: begin
                    if (result != 16'h0000) begin
                        s_nxt.flags.z = 1'b0; // RULE_02
                    end
                    s_nxt.flags.c = word_size ? full_sum[16] : full_sum[8];
                end
                OP_DAA, OP_DAS: begin
                    if (adjust_carry) begin
                        s_nxt.flags.c = 1'b1; // RULE_03
                    end
                    s_nxt.flags.z = (adjust_value == 8'h00);
                end
                OP_DIVIDE: begin
                    s_nxt.flags.n = divisor[7]; // RULE_05
                    s_nxt.flags.z = (divisor[7:0] == 8'h00); // RULE_06
                end
                default: s_nxt.flags = s_r.flags;
            endcase
        end
        if (copy_done_w) begin
            s_nxt.states = copy_states; // RULE_04
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Block copy
    cod_copy_engine u_copy (
        .clock(clock),
        .rst(rst),
        .start(copy_start),
        .count_in(copy_count_reg),
        .src_in(copy_source_ptr),
        .dst_in(copy_dest_ptr),
        .mem_rd(mem_rd),
        .mem_wr(mem_wr),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .busy(copy_busy),
        .done(copy_done_w),
        .count_out(copy_count_out),
        .src_out(copy_source_out),
        .dst_out(copy_dest_out),
        .states_used(copy_states)
    );

    assign copy_done = copy_done_w;
    assign decoded = s_r.dec;
    assign condition_flags_reg = s_r.flags;
    assign exec_states = s_r.states;
endmodule
`default_nettype wire

// *** cod_pkg.sv ***
// Package for the opcode decoder and execution timing block
`default_nettype none
package cod_pkg;
    localparam int CLOCK_PERIOD_NS = 4;
    localparam logic [3:0] HALF_CARRY_BIT = 4'hB;
    localparam logic [3:0] BRANCH_ROW = 4'h4;
    localparam logic [3:0] IMM_ROW_FIRST = 4'h8;
    localparam logic [3:0] SHARED_SEL_BIT = 4'h7;
    localparam logic [3:0] MEM_STATES = 4'h2;
    localparam logic [3:0] INTERNAL_STATES = 4'h1;
    localparam logic [3:0] PERIPH_FAST_STATES = 4'h2;
    localparam logic [3:0] PERIPH_SLOW_STATES = 4'h3;
    localparam logic [11:0] COPY_STATES_PER_BYTE = 12'h004;
    localparam logic [11:0] COPY_FIXED_STATES = 12'h009;
    localparam logic [7:0] COPY_OPCODE = 8'h7B;
    localparam logic [7:0] DIVIDE_OPCODE = 8'h51;
    localparam logic [7:0] DAA_OPCODE = 8'h0F;
    localparam logic [7:0] DAS_OPCODE = 8'h1F;
    localparam logic [7:0] ADD_WITH_CARRY_INSTR_OPCODE = 8'h0E;
    localparam logic [7:0] SUB_WITH_CARRY_INSTR_OPCODE = 8'h1E;
    localparam logic [7:0] INDIRECT_MOVE_OPCODE = 8'h6D;

    typedef enum logic [4:0] {
        OP_OTHER, OP_ADD, OP_ADD_WITH_CARRY_INSTR, OP_CMP, OP_SUB_WITH_CARRY_INSTR, OP_OR, OP_XOR, OP_AND, OP_MOV,
        OP_BRANCH, OP_COPY, OP_DIVIDE, OP_DAA, OP_DAS, OP_SHARED_A, OP_SHARED_B,
        OP_PUSH_POP, OP_SUB
    } cod_op_type;

    typedef struct packed {
        logic c;
        logic v;
        logic z;
        logic n;
        logic h;
    } cod_flags_type;

    typedef struct packed {
        cod_op_type op;
        logic [3:0] cond;
        logic imm_byte;
    } cod_decode_type;

    typedef struct packed {
        logic [3:0] fetch;
        logic [3:0] branch_read;
        logic [3:0] stack;
        logic [3:0] byte_data;
        logic [3:0] word_data;
        logic [3:0] internal;
    } cod_cycles_type;

    typedef enum {ST_IDLE, ST_READ, ST_WRITE, ST_DONE} cod_copy_state_type;

    typedef struct packed {
        cod_copy_state_type state;
        logic [7:0] count;
        logic [15:0] src;
        logic [15:0] dst;
        logic [7:0] data;
        logic [11:0] states;
        logic busy;
    } cod_copy_type;
endpackage
`default_nettype wire

// *** cod_copy_engine.sv ***
// Block-copy sequencer: moves bytes and counts execution states
`default_nettype none
module cod_copy_engine
    import cod_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Start and operands
    input wire logic start,
    input wire logic [7:0] count_in,
    input wire logic [15:0] src_in,
    input wire logic [15:0] dst_in,
    // Memory port
    output logic mem_rd,
    output logic mem_wr,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Status
    output logic busy,
    output logic done,
    output logic [7:0] count_out,
    output logic [15:0] src_out,
    output logic [15:0] dst_out,
    output logic [11:0] states_used
);
    cod_copy_type s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        case (s_r.state)
            ST_IDLE: begin
                if (start) begin
                    s_nxt.count = count_in;
                    s_nxt.src = src_in;
                    s_nxt.dst = dst_in;
                    s_nxt.busy = 1'b1;
                    s_nxt.states = COPY_FIXED_STATES; // RULE_04
                    s_nxt.state = (count_in != 8'h00) ? ST_READ : ST_DONE; // RULE_14
                end
            end
            ST_READ: begin
                s_nxt.data = mem_rdata;
                s_nxt.state = ST_WRITE;
            end
            ST_WRITE: begin
                s_nxt.src = s_r.src + 16'h0001; // RULE_14
                s_nxt.dst = s_r.dst + 16'h0001;
                s_nxt.count = s_r.count - 8'h01;
                s_nxt.states = s_r.states + COPY_STATES_PER_BYTE; // RULE_04
                s_nxt.state = (s_r.count == 8'h01) ? ST_DONE : ST_READ;
            end
            ST_DONE: begin
                s_nxt.busy = 1'b0;
                s_nxt.state = ST_IDLE;
            end
            default: s_nxt.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '{state: ST_IDLE, count: 8'h00, src: 16'h0000, dst: 16'h0000,
                     data: 8'h00, states: 12'h000, busy: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mem_rd = (s_r.state == ST_READ);
    assign mem_wr = (s_r.state == ST_WRITE);
    assign mem_addr = (s_r.state == ST_WRITE) ? s_r.dst : s_r.src;
    assign mem_wdata = s_r.data;
    assign busy = s_r.busy;
    assign done = (s_r.state == ST_DONE);
    assign count_out = s_r.count;
    assign src_out = s_r.src;
    assign dst_out = s_r.dst;
    assign states_used = s_r.states;
endmodule
`default_nettype wire

// *** cod_mem_model.sv ***
// Behavioural on-chip memory behind the block-copy port
`default_nettype none
module cod_mem_model
    import cod_pkg::*;
(
    // Clock
    input wire logic clock,
    // Memory port
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h00;
    // Outside a read the data lines never show the stale byte
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_r;
    always @(posedge clock) begin
        if (mem_rd) last_r <= mem[mem_addr];
        if (mem_wr) mem[mem_addr] <= mem_wdata;
    end
endmodule
`default_nettype wire

// *** cod_decoder_sva.sv ***
// Concurrent checks on the opcode decoder ports
`default_nettype none
module cod_decoder_sva
    import cod_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Inputs
    input wire logic issue,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] divisor,
    input wire logic adjust_carry,
    input wire logic [3:0] stack_ptr_reg,
    input wire logic [7:0] mem_rdata,
    // Outputs
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire cod_decode_type decoded,
    input wire cod_flags_type condition_flags_reg
);
    logic [7:0] op8;
    assign op8 = instr_word[15:8];
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_branch;
        issue && op8[7:4] == BRANCH_ROW |=> decoded.op == OP_BRANCH && decoded.cond == $past(instr_word[11:8]);
    endproperty
    a_branch: assert property (p_branch) else $error("branch decode wrong");
    property p_imm;
        issue && op8[7] |=> decoded.imm_byte && decoded.op == cod_op_type'({2'b00, $past(instr_word[14:12])} + 5'd1);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate row decode wrong");
    property p_shared;
        issue && op8 == 8'h67 |=> decoded.op == ($past(instr_word[7]) ? OP_SHARED_B : OP_SHARED_A);
    endproperty
    a_shared: assert property (p_shared) else $error("shared cell split wrong");
    property p_push;
        issue && op8 == INDIRECT_MOVE_OPCODE && instr_word[6:4] == stack_ptr_reg[2:0] |=> decoded.op == OP_PUSH_POP;
    endproperty
    a_push: assert property (p_push) else $error("stack move decode wrong");
    property p_div_n;
        issue && op8 == DIVIDE_OPCODE |=> condition_flags_reg.n == $past(divisor[7]);
    endproperty
    a_div_n: assert property (p_div_n) else $error("divide negative flag wrong");
    property p_div_z;
        issue && op8 == DIVIDE_OPCODE |=> condition_flags_reg.z == ($past(divisor[7:0]) == 8'h00);
    endproperty
    a_div_z: assert property (p_div_z) else $error("divide zero flag wrong");
    property p_daa;
        issue && op8 == DAA_OPCODE |=> condition_flags_reg.c == ($past(adjust_carry) || $past(condition_flags_reg.c));
    endproperty
    a_daa: assert property (p_daa) else $error("adjust carry wrong");
    property p_step;
        mem_rd |=> mem_wr && mem_wdata == $past(mem_rdata);
    endproperty
    a_step: assert property (p_step) else $error("copy byte not written next");
endmodule
bind cod_decoder cod_decoder_sva i_cod_decoder_sva (.clock, .rst, .issue, .instr_word, .divisor, .adjust_carry,
    .stack_ptr_reg, .mem_rdata, .mem_rd, .mem_wr, .mem_wdata, .decoded, .condition_flags_reg);
`default_nettype wire

// *** cod_tb.sv ***
// Self-checking bench for the opcode decoder and block copy
`default_nettype none
module testbench import cod_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic issue = 1'b0;
    logic is_subtract = 1'b0;
    logic word_size = 1'b0;
    logic adjust_carry = 1'b0;
    logic data_in_periph = 1'b0;
    logic periph_slow = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [15:0] operand_a = 16'h0000;
    logic [15:0] operand_b = 16'h0000;
    logic [15:0] divisor = 16'h0000;
    logic [15:0] copy_source_ptr = 16'h0100;
    logic [15:0] copy_dest_ptr = 16'h0200;
    logic [7:0] adjust_value = 8'h00;
    logic [7:0] copy_count_reg = 8'h00;
    logic [3:0] stack_ptr_reg = 4'h7;
    cod_cycles_type cycles = '0;
    logic mem_rd, mem_wr, copy_busy, copy_done;
    logic [15:0] mem_addr, copy_source_out, copy_dest_out;
    logic [7:0] mem_wdata, mem_rdata, copy_count_out;
    logic [11:0] exec_states;
    cod_decode_type decoded;
    cod_flags_type condition_flags_reg;
    int fail_count = 0;
    int check_count = 0;
    always #2 clock = ~clock;
    cod_decoder i_cod_decoder (.clock, .rst, .issue, .instr_word, .operand_a, .operand_b, .is_subtract,
        .word_size, .adjust_value, .adjust_carry, .divisor, .stack_ptr_reg, .cycles, .data_in_periph,
        .periph_slow, .copy_count_reg, .copy_source_ptr, .copy_dest_ptr, .mem_rd, .mem_wr, .mem_addr,
        .mem_wdata, .mem_rdata, .decoded, .condition_flags_reg, .exec_states, .copy_busy, .copy_done,
        .copy_count_out, .copy_source_out, .copy_dest_out);
    cod_mem_model i_cod_mem_model (.clock, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);
    ////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic run(input logic [15:0] w);
        @(negedge clock);
        instr_word = w;
        issue = 1'b1;
        @(negedge clock);
        issue = 1'b0;
    endtask
    task automatic close_out;
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_div;
        divisor = 16'h0080;
        run({DIVIDE_OPCODE, 8'h00});
        chk("div n", 16'h0001, 16'(condition_flags_reg.n));
        chk("div z", 16'h0000, 16'(condition_flags_reg.z));
        divisor = 16'h0000;
        run({DIVIDE_OPCODE, 8'h00});
        chk("div n", 16'h0000, 16'(condition_flags_reg.n));
        chk("div z", 16'h0001, 16'(condition_flags_reg.z));
    endtask
    task automatic t_add_with_carry_instr;
        run({ADD_WITH_CARRY_INSTR_OPCODE, 8'h00});
        chk("add_with_carry_instr z", 16'h0001, 16'(condition_flags_reg.z));
        operand_a = 16'h0001;
        run({SUB_WITH_CARRY_INSTR_OPCODE, 8'h00});
        chk("sub_with_carry_instr z", 16'h0000, 16'(condition_flags_reg.z));
        operand_a = 16'h0000;
        run({ADD_WITH_CARRY_INSTR_OPCODE, 8'h00});
        chk("add_with_carry_instr z", 16'h0000, 16'(condition_flags_reg.z));
    endtask
    task automatic t_daa;
        run({DAA_OPCODE, 8'h00});
        chk("adj c", 16'h0000, 16'(condition_flags_reg.c));
        adjust_carry = 1'b1;
        run({DAA_OPCODE, 8'h00});
        chk("adj c", 16'h0001, 16'(condition_flags_reg.c));
        adjust_carry = 1'b0;
        run({DAS_OPCODE, 8'h00});
        chk("adj c", 16'h0001, 16'(condition_flags_reg.c));
    endtask
    task automatic t_half;
        word_size = 1'b1;
        operand_a = 16'h0800;
        operand_b = 16'h0800;
        run(16'h0901);
        chk("h set", 16'h0001, 16'(condition_flags_reg.h));
        operand_a = 16'h0700;
        run(16'h0901);
        chk("h clr", 16'h0000, 16'(condition_flags_reg.h));
        word_size = 1'b0;
    endtask
    task automatic t_branch;
        for (int i = 0; i < 16; i++) begin
            run({BRANCH_ROW, i[3:0], 8'h10});
            chk("br op", 16'(OP_BRANCH), 16'(decoded.op));
            chk("br cond", 16'(i), 16'(decoded.cond));
        end
    endtask
    task automatic t_imm;
        for (int r = 0; r < 8; r++) begin
            run({1'b1, r[2:0], 12'h345});
            chk("imm op", 16'(r + 1), 16'(decoded.op));
            chk("imm flag", 16'h0001, 16'(decoded.imm_byte));
        end
    endtask
    task automatic t_shared;
        run(16'h6730);
        chk("shared lo", 16'(OP_SHARED_A), 16'(decoded.op));
        run(16'h67B0);
        chk("shared hi", 16'(OP_SHARED_B), 16'(decoded.op));
        run(16'h6D70);
        chk("push", 16'(OP_PUSH_POP), 16'(decoded.op));
    endtask
    task automatic t_states;
        cycles = '{4'h2, 4'h1, 4'h1, 4'h2, 4'h1, 4'h3};
        data_in_periph = 1'b1;
        periph_slow = 1'b1;
        run(16'h0000);
        chk("states slow", 16'd19, 16'(exec_states));
        periph_slow = 1'b0;
        run(16'h0000);
        chk("states fast", 16'd17, 16'(exec_states));
        data_in_periph = 1'b0;
        periph_slow = 1'b1;
        run(16'h0000);
        chk("states mem", 16'd17, 16'(exec_states));
    endtask
    task automatic t_copy(input logic [7:0] n);
        for (int k = 0; k < n; k++) i_cod_mem_model.mem[16'h0100 + k] = 8'hA0 + 8'(k);
        copy_count_reg = n;
        run({COPY_OPCODE, 8'h00});
        for (int k = 0; k < 40 && copy_done !== 1'b1; k++) @(negedge clock);
        chk("copy done", 16'h0001, 16'(copy_done));
        @(negedge clock);
        chk("copy states", {6'h00, n, 2'b00} + 16'h0009, 16'(exec_states));
        chk("copy count", 16'h0000, 16'(copy_count_out));
        chk("copy busy", 16'h0000, 16'(copy_busy));
        chk("copy src", 16'h0100 + 16'(n), copy_source_out);
        chk("copy dst", 16'h0200 + 16'(n), copy_dest_out);
        for (int k = 0; k < n; k++) chk("copy byte", 16'(8'hA0 + k), 16'(i_cod_mem_model.mem[16'h0200 + k]));
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        t_div;
        t_add_with_carry_instr;
        t_daa;
        t_half;
        t_branch;
        t_imm;
        t_shared;
        t_states;
        t_copy(8'h03);
        t_copy(8'h00);
        close_out;
    end
    initial begin
        #20000;
        fail_count++;
        close_out;
    end
endmodule
`default_nettype wire
